// ### core/tosp_map.svh
// register offsets, field positions and reset values of the output stage
`ifndef TOSP_MAP_SVH
`define TOSP_MAP_SVH
// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define TOSP_OFS_CEP1 8'h0c
`define TOSP_OFS_CEP2 8'h0d
`define TOSP_OFS_CNTH 8'h0e
`define TOSP_OFS_CNTL 8'h0f
`define TOSP_OFS_DIVH 8'h10
`define TOSP_OFS_DIVL 8'h11
`define TOSP_OFS_CTRL 8'h20
`define TOSP_OFS_IDLE 8'h21
`define TOSP_OFS_DEAD 8'h22
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define TOSP_CTRL_CEN 0
`define TOSP_CTRL_CPRE 1
`define TOSP_CTRL_RUNOFF 2
`define TOSP_CTRL_OSSI 3
`define TOSP_CTRL_OUTEN 4
`define TOSP_CTRL_UPDGEN 5
// per channel nibble: enable, polarity, compl enable, compl polarity
`define TOSP_FLD_ME 0
`define TOSP_FLD_MP 1
`define TOSP_FLD_CE 2
`define TOSP_FLD_CP 3
`define TOSP_CEP2_USED 6
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TOSP_RST_BYTE 8'h00
`define TOSP_RST_WORD 16'h0000
`endif

// ### core/tosp_pkg.sv
// shared types of the output stage and prescaler
package tosp_pkg;
	typedef logic [7:0] tosp_byte_t;   // one register byte
	typedef logic [15:0] tosp_word_t;  // counter and divider width
	// drive kind of one output pin, for readability of the pin logic
	typedef enum logic [1:0] {
		TOSP_DRV_OFF = 2'h0,
		TOSP_DRV_WAVE = 2'h1,
		TOSP_DRV_INACT = 2'h3,
		TOSP_DRV_IDLE = 2'h2
	} tosp_drive_t;
endpackage

// ### core/tosp_top.sv
// timer output stage, counter value and 16-bit prescaler
//
// Notes on behaviour
// - input channel enable gates capture strobe
// - pair enables update on commutation when preloaded
// - run off-state clear: disabled outputs undriven
// - main only: output is wave xor polarity
// - complementary only: wave xor complementary polarity
// - both enabled: complementary waves with dead time
// - run off-state set: disabled output held inactive if its pair partner is enabled
// - idle off-state clear: both outputs undriven
// - idle off-state set: polarity, then idle level; channel 4 idle level at once
// - second enable register: bits 7:6 read zero
// - counter as high and low bytes, reset zero
// - counter clock is input over divider plus one
// - divider takes effect only at update event
// - update generate and trigger reset load divider
// - break clears main output enable at once
//
// Added by the designer: the strobed register port.
`include "tosp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tosp_top (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [3:0] chan_reference_wave,
	input wire logic [3:0] chan_input_mode,
	input wire logic [3:0] capture_trigger,
	input wire logic update_event,
	input wire logic trigger_reset,
	input wire logic commutation_event,
	input wire logic break_in,
	input wire logic auto_output_enable,
	output logic [3:0] chan_main_output,
	output logic [3:0] chan_main_oe,
	output logic [2:0] chan_compl_output,
	output logic [2:0] chan_compl_oe,
	output logic [3:0] capture_strobe,
	output logic [15:0] capture_value,
	output logic [15:0] counter_value,
	output logic counter_clock,
	output logic main_output_enable
);
	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	tosp_pkg::tosp_byte_t cep1_q;      // preload enables, channels 1 and 2
	logic [5:0] cep2_q;                // preload enables, channels 3 and 4
	logic [11:0] act_q;                // active enables of the three pairs
	logic cnt_en_q;                    // counter runs
	logic cpre_q;                      // commutation_preload_ctrl
	logic runoff_q;                    // run_off_state_select
	logic ossi_q;                      // idle-mode off-state select
	logic [6:0] idle_q;                // idle levels, main/compl per channel
	tosp_pkg::tosp_byte_t dead_q;      // dead time in clk_sys cycles
	tosp_pkg::tosp_word_t div_reg_q;   // divider_register, software copy
	tosp_pkg::tosp_word_t div_act_q;   // active divider
	tosp_pkg::tosp_word_t div_cnt_q;   // divider position
	tosp_pkg::tosp_byte_t cnt_hbuf_q;  // high byte waiting for low write
	tosp_pkg::tosp_byte_t div_hbuf_q;  // high byte waiting for low write
	tosp_pkg::tosp_byte_t cnt_lbuf_q;  // low byte caught by a high read
	logic outen_prev_q;                // main enable one cycle ago
	logic [3:0] ref_q;                 // registered reference waves
	tosp_pkg::tosp_byte_t dt_cnt_q [0:2]; // dead time left per pair
	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic wr_ctrl, wr_cntl, updgen_w, upd_w, tick_w;
	logic [3:0] m_v, m_oe;
	logic [2:0] c_v, c_oe;
	assign wr_ctrl = reg_wr && (reg_addr == `TOSP_OFS_CTRL);
	assign wr_cntl = reg_wr && (reg_addr == `TOSP_OFS_CNTL);
	assign updgen_w = wr_ctrl && reg_wdata[`TOSP_CTRL_UPDGEN];
	// every source of an update event reloads the divider
	assign upd_w = update_event || updgen_w || trigger_reset;
	// counter clock enable: one pulse each divider+1 cycles
	assign tick_w = cnt_en_q && !upd_w && (div_cnt_q == div_act_q);
	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	// configuration bytes; update generate is a write-only pulse
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cep1_q <= `TOSP_RST_BYTE;
			cep2_q <= 6'h00;
			idle_q <= 7'h00;
			dead_q <= `TOSP_RST_BYTE;
			{cnt_en_q, cpre_q, runoff_q, ossi_q} <= 4'h0;
			cnt_hbuf_q <= `TOSP_RST_BYTE;
			div_hbuf_q <= `TOSP_RST_BYTE;
			div_reg_q <= `TOSP_RST_WORD;
		end else if (reg_wr) begin
			case (reg_addr)
				`TOSP_OFS_CEP1: cep1_q <= reg_wdata;
				// upper bits are reserved and not stored
				`TOSP_OFS_CEP2: cep2_q <= reg_wdata[5:0];
				`TOSP_OFS_CNTH: cnt_hbuf_q <= reg_wdata;
				`TOSP_OFS_DIVH: div_hbuf_q <= reg_wdata;
				`TOSP_OFS_DIVL: div_reg_q <= {div_hbuf_q, reg_wdata};
				`TOSP_OFS_IDLE: idle_q <= reg_wdata[6:0];
				`TOSP_OFS_DEAD: dead_q <= reg_wdata;
				`TOSP_OFS_CTRL: begin
					cnt_en_q <= reg_wdata[`TOSP_CTRL_CEN];
					cpre_q <= reg_wdata[`TOSP_CTRL_CPRE];
					runoff_q <= reg_wdata[`TOSP_CTRL_RUNOFF];
					ossi_q <= reg_wdata[`TOSP_CTRL_OSSI];
				end
				default: ; // unmapped writes are dropped
			endcase
		end
	end
	// main output enable: break clears it without the clock
	always_ff @(posedge clk_sys or posedge sys_rst or posedge break_in) begin
		if (sys_rst || break_in) begin
			main_output_enable <= 1'b0;
		end else if (auto_output_enable) begin
			main_output_enable <= 1'b1;
		end else if (wr_ctrl) begin
			main_output_enable <= reg_wdata[`TOSP_CTRL_OUTEN];
		end
	end
	// active pair enables: follow preload, or wait for commutation
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			act_q <= 12'h000;
		end else if (!cpre_q || commutation_event) begin
			act_q <= {cep2_q[3:0], cep1_q};
		end
	end
	// ----------------------------------------------------------------
	// read port: data one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= `TOSP_RST_BYTE;
			cnt_lbuf_q <= `TOSP_RST_BYTE;
		end else if (reg_rd) begin
			case (reg_addr)
				`TOSP_OFS_CEP1: reg_rdata <= cep1_q;
				`TOSP_OFS_CEP2: reg_rdata <= {2'h0, cep2_q};
				`TOSP_OFS_CNTH: begin
					// catch the low half so the pair reads coherently
					reg_rdata <= counter_value[15:8];
					cnt_lbuf_q <= counter_value[7:0];
				end
				`TOSP_OFS_CNTL: reg_rdata <= cnt_lbuf_q;
				`TOSP_OFS_DIVH: reg_rdata <= div_reg_q[15:8];
				`TOSP_OFS_DIVL: reg_rdata <= div_reg_q[7:0];
				`TOSP_OFS_IDLE: reg_rdata <= {1'b0, idle_q};
				`TOSP_OFS_DEAD: reg_rdata <= dead_q;
				`TOSP_OFS_CTRL: reg_rdata <= {3'h0, main_output_enable, ossi_q,
					runoff_q, cpre_q, cnt_en_q};
				default: reg_rdata <= `TOSP_RST_BYTE; // unmapped reads zero
			endcase
		end else begin
			reg_rdata <= `TOSP_RST_BYTE;
		end
	end
	// ----------------------------------------------------------------
	// prescaler and counter
	// ----------------------------------------------------------------
	// divider: reload only at update events, never on a write
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			div_act_q <= `TOSP_RST_WORD;
			div_cnt_q <= `TOSP_RST_WORD;
		end else if (upd_w) begin
			div_act_q <= div_reg_q;
			div_cnt_q <= `TOSP_RST_WORD;
		end else if (cnt_en_q) begin
			div_cnt_q <= tick_w ? `TOSP_RST_WORD : div_cnt_q + 16'h0001;
		end
	end
	// counter: software write wins over clear and count
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			counter_value <= `TOSP_RST_WORD;
			counter_clock <= 1'b0;
		end else begin
			counter_clock <= tick_w;
			if (wr_cntl) begin
				counter_value <= {cnt_hbuf_q, reg_wdata};
			end else if (updgen_w || trigger_reset) begin
				counter_value <= `TOSP_RST_WORD;
			end else if (tick_w) begin
				counter_value <= counter_value + 16'h0001;
			end
		end
	end
	// ----------------------------------------------------------------
	// capture gate
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			capture_strobe <= 4'h0;
			capture_value <= `TOSP_RST_WORD;
		end else begin
			// a disabled input channel never raises its capture strobe; capture_value still loads on any triggered input channel
			capture_strobe <= capture_trigger & chan_input_mode &
				{cep2_q[4], act_q[8], act_q[4], act_q[0]};
			if (|(capture_trigger & chan_input_mode)) begin
				capture_value <= counter_value;
			end
		end
	end
	// ----------------------------------------------------------------
	// pair output stages with dead time
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			outen_prev_q <= 1'b0;
			ref_q <= 4'h0;
		end else begin
			outen_prev_q <= main_output_enable;
			ref_q <= chan_reference_wave;
		end
	end
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_pair
			logic me, mp, ne, np, quiet, m_act, c_act;
			tosp_pkg::tosp_drive_t mdrv, cdrv;
			assign me = act_q[4*gi+`TOSP_FLD_ME];
			assign mp = act_q[4*gi+`TOSP_FLD_MP];
			assign ne = act_q[4*gi+`TOSP_FLD_CE];
			assign np = act_q[4*gi+`TOSP_FLD_CP];
			assign quiet = (dt_cnt_q[gi] == 8'h00);
			// active edges wait for the dead time, inactive edges do not
			assign m_act = ref_q[gi] && quiet;
			assign c_act = !ref_q[gi] && quiet;
			// reload on a wave edge while running, or on falling enable
			always_ff @(posedge clk_sys or posedge sys_rst) begin
				if (sys_rst) begin
					dt_cnt_q[gi] <= 8'h00;
				end else if ((main_output_enable && chan_reference_wave[gi] != ref_q[gi])
					|| (outen_prev_q && !main_output_enable)) begin
					dt_cnt_q[gi] <= dead_q;
				end else if (!quiet) begin
					dt_cnt_q[gi] <= dt_cnt_q[gi] - 8'h01;
				end
			end
			// drive kind per pin from the enable state
			always_comb begin
				mdrv = tosp_pkg::TOSP_DRV_OFF;
				cdrv = tosp_pkg::TOSP_DRV_OFF;
				if (main_output_enable) begin
					if (me) begin
						mdrv = tosp_pkg::TOSP_DRV_WAVE;
					end else if (runoff_q && ne) begin
						mdrv = tosp_pkg::TOSP_DRV_INACT;
					end
					if (ne) begin
						cdrv = tosp_pkg::TOSP_DRV_WAVE;
					end else if (runoff_q && me) begin
						cdrv = tosp_pkg::TOSP_DRV_INACT;
					end
				end else if (ossi_q) begin
					// inactive first, idle level once the dead time ran out
					mdrv = quiet ? tosp_pkg::TOSP_DRV_IDLE : tosp_pkg::TOSP_DRV_INACT;
					cdrv = mdrv;
				end
			end
			// pin values; disabled pins stay off
			always_comb begin
				m_oe[gi] = (mdrv != tosp_pkg::TOSP_DRV_OFF);
				c_oe[gi] = (cdrv != tosp_pkg::TOSP_DRV_OFF);
				case (mdrv)
					tosp_pkg::TOSP_DRV_WAVE: m_v[gi] = (ne ? m_act : ref_q[gi]) ^ mp;
					tosp_pkg::TOSP_DRV_IDLE: m_v[gi] = idle_q[2*gi];
					default: m_v[gi] = mp;
				endcase
				case (cdrv)
					tosp_pkg::TOSP_DRV_WAVE: c_v[gi] = (me ? c_act : ref_q[gi]) ^ np;
					tosp_pkg::TOSP_DRV_IDLE: c_v[gi] = idle_q[2*gi+1];
					default: c_v[gi] = np;
				endcase
			end
		end
	endgenerate
	// channel 4 has no complementary pin and no dead time
	always_comb begin
		m_oe[3] = main_output_enable ? cep2_q[4] : ossi_q;
		m_v[3] = main_output_enable ? (ref_q[3] ^ cep2_q[5]) : idle_q[6];
	end
	// pins come straight from flops
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			chan_main_output <= 4'h0;
			chan_main_oe <= 4'h0;
			chan_compl_output <= 3'h0;
			chan_compl_oe <= 3'h0;
		end else begin
			chan_main_output <= m_v;
			chan_main_oe <= m_oe;
			chan_compl_output <= c_v;
			chan_compl_oe <= c_oe;
		end
	end
	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	chk_capture_gate: assert property (capture_strobe[0] |->
		$past(act_q[0]) && $past(capture_trigger[0])) else $error("capture while disabled");
	chk_preload_hold: assert property (cpre_q && !commutation_event |=>
		$stable(act_q)) else $error("enables moved without commutation");
	chk_run_off_undriven: assert property (main_output_enable && !runoff_q && !act_q[0]
		|=> !chan_main_oe[0]) else $error("disabled pin driven");
	chk_main_only: assert property (main_output_enable && act_q[0] && !act_q[2]
		|=> chan_main_oe[0] && chan_main_output[0] == ($past(ref_q[0]) ^ $past(act_q[1])))
		else $error("main wave wrong");
	chk_compl_only: assert property (main_output_enable && !act_q[0] && act_q[2]
		|=> chan_compl_oe[0] && chan_compl_output[0] == ($past(ref_q[0]) ^ $past(act_q[3])))
		else $error("compl wave wrong");
	chk_dead_inactive: assert property (main_output_enable && act_q[0] && act_q[2]
		&& dt_cnt_q[0] != 8'h00 |=> chan_main_output[0] == $past(act_q[1])
		&& chan_compl_output[0] == $past(act_q[3])) else $error("active in dead time");
	chk_run_off_inact: assert property (main_output_enable && runoff_q && !act_q[0] && act_q[2]
		|=> chan_main_oe[0] && chan_main_output[0] == $past(act_q[1]))
		else $error("off state level wrong");
	chk_idle_undriven: assert property (!main_output_enable && !ossi_q
		|=> chan_main_oe == 4'h0 && chan_compl_oe == 3'h0) else $error("idle pin driven");
	chk_idle_level: assert property (!main_output_enable && ossi_q && dt_cnt_q[1] == 8'h00
		|=> chan_main_output[1] == $past(idle_q[2])) else $error("idle level wrong");
	chk_resv_zero: assert property (reg_rd && reg_addr == `TOSP_OFS_CEP2
		|=> reg_rdata[7:6] == 2'h0) else $error("reserved bits set");
	chk_cnt_write: assert property (wr_cntl |=> counter_value ==
		{$past(cnt_hbuf_q), $past(reg_wdata)}) else $error("counter write lost");
	chk_div_period: assert property (upd_w && cnt_en_q && div_reg_q == 16'h0002
		##1 (cnt_en_q && !upd_w)[*3] |=> counter_clock) else $error("divide ratio wrong");
	chk_div_hold: assert property (!upd_w |=> $stable(div_act_q))
		else $error("divider changed without update");
	chk_updgen_load: assert property ((updgen_w || trigger_reset) && !wr_cntl
		|=> div_act_q == $past(div_reg_q) && counter_value == 16'h0000)
		else $error("update did not load");
	chk_break_moe: assert property (break_in |-> !main_output_enable)
		else $error("enable survived break");
	cov_break: cover property (main_output_enable ##1 break_in);
	cov_commute: cover property (cpre_q && commutation_event ##1 $changed(act_q));
	cov_dead: cover property (act_q[0] && act_q[2] && dt_cnt_q[0] != 8'h00);
	cov_capture: cover property (capture_strobe[0]);
endmodule
`default_nettype wire

// ### sim/tosp_switch_model.sv
// load-side model of the channel 1 power switch pair
`timescale 1ns/1ps
`default_nettype none
module tosp_switch_model (
	input wire logic clk_sys,
	input wire logic drv_main,
	input wire logic drv_main_oe,
	input wire logic drv_compl,
	input wire logic drv_compl_oe,
	input wire logic main_pol,
	input wire logic compl_pol,
	output logic main_pin,
	output logic compl_pin,
	output int shoot_cnt
);
	// ----------------------------------------------------------------
	// gate lines
	// ----------------------------------------------------------------
	// a released gate is pulled low by the driver stage, never left at its last level
	assign main_pin = drv_main_oe ? drv_main : 1'b0;
	assign compl_pin = drv_compl_oe ? drv_compl : 1'b0;
	// ----------------------------------------------------------------
	// shoot-through watch
	// ----------------------------------------------------------------
	// both switches on together would short the supply, so every such cycle is counted
	always_ff @(posedge clk_sys) begin
		// a released gate switches nothing on, whatever its polarity
		if (drv_main_oe && drv_compl_oe && main_pin != main_pol && compl_pin != compl_pol) begin
			shoot_cnt <= shoot_cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ### sim/tosp_top_tb.sv
// self-checking bench for the output stage, counter and prescaler
`include "tosp_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tosp_top_tb;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_v;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] ref_w = 4'h0, in_mode = 4'h0, cap_trig = 4'h0, main_out, main_oe, cap_stb;
	logic upd = 1'b0, trg_rst = 1'b0, comm = 1'b0, brk = 1'b0, aoe = 1'b0;
	logic [2:0] compl_out, compl_oe;
	logic [15:0] cap_val, cnt_val, d, prev;
	logic cnt_clk, out_en, main_pin, compl_pin, mp = 1'b0, cp = 1'b0;
	logic [31:0] rnd;
	int shoot_cnt, error_cnt = 0, check_count = 0, seed = 48818, stb_n = 0, i, n, c0;
	always #10 clk_sys = ~clk_sys;
	tosp_top dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.chan_reference_wave(ref_w), .chan_input_mode(in_mode), .capture_trigger(cap_trig),
		.update_event(upd), .trigger_reset(trg_rst), .commutation_event(comm),
		.break_in(brk), .auto_output_enable(aoe), .chan_main_output(main_out),
		.chan_main_oe(main_oe), .chan_compl_output(compl_out), .chan_compl_oe(compl_oe),
		.capture_strobe(cap_stb), .capture_value(cap_val), .counter_value(cnt_val),
		.counter_clock(cnt_clk), .main_output_enable(out_en));
	tosp_switch_model load (.clk_sys(clk_sys), .drv_main(main_out[0]),
		.drv_main_oe(main_oe[0]), .drv_compl(compl_out[0]), .drv_compl_oe(compl_oe[0]),
		.main_pol(mp), .compl_pol(cp), .main_pin(main_pin), .compl_pin(compl_pin),
		.shoot_cnt(shoot_cnt));
	// channel 2 capture strobes, counted for the gating check
	always @(posedge clk_sys) if (cap_stb[1]) stb_n <= stb_n + 1;
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		if (error_cnt == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// wait k edges, then step past them so settled values are sampled
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	// one-cycle pulse: 0 update, 1 trigger reset, 2 commutation, 3 auto enable, else capture
	task automatic fire(input int w);
		@(posedge clk_sys);
		case (w)
			0: upd <= 1'b1;
			1: trg_rst <= 1'b1;
			2: comm <= 1'b1;
			3: aoe <= 1'b1;
			default: cap_trig <= 4'h2;
		endcase
		@(posedge clk_sys);
		{upd, trg_rst, comm, aoe} <= 4'h0;
		cap_trig <= 4'h0;
	endtask
	// cycles between the third and fourth counter ticks, the first two skipped as they may predate a reload
	task automatic gap(output int g);
		int k;
		k = 0;
		repeat (2) begin
			g = 1;
			cyc(1);
			while (cnt_clk !== 1'b1 && k < 200) begin
				cyc(1);
				k++;
			end
			cyc(1);
			while (cnt_clk !== 1'b1 && g < 200) begin
				cyc(1);
				g++;
			end
		end
	endtask
	// expected {main oe, main pin, compl oe, compl pin} with moe set, released pins read 0
	function automatic logic [3:0] exp_pins(input logic me, ce, roff, r, pm, pc);
		logic om, oc;
		om = me | (roff & ce);
		oc = ce | (roff & me);
		return {om, om & (me ? r ^ pm : pm), oc, oc & (ce ? r ^ me ^ pc : pc)};
	endfunction
	// one enable combination of channel 1, random polarities and reference levels
	task automatic pins(input logic me, input logic ce, input logic roff);
		rnd = $random(seed);
		mp = rnd[1];
		cp = rnd[2];
		wr(`TOSP_OFS_CTRL, {3'h0, 1'b1, 1'b0, roff, 2'h0});
		wr(`TOSP_OFS_CEP1, {4'h0, cp, ce, mp, me});
		cyc(12);
		c0 = shoot_cnt;
		repeat (2) begin
			rnd = $random(seed);
			@(posedge clk_sys);
			ref_w <= {3'h0, rnd[0]};
			cyc(12);
			chk("ch1 pins", {12'h0, exp_pins(me, ce, roff, rnd[0], mp, cp)}, {12'h0, main_oe[0], main_pin, compl_oe[0], compl_pin});
		end
		chk("shoot-through", 16'(c0), 16'(shoot_cnt));
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (i = 8'h0d; i <= 8'h11; i++) begin
			rd(8'(i), rd_v);
			chk_reg("reset value", 8'h00, rd_v);
		end
		rd(8'h30, rd_v);
		chk_reg("unmapped read", 8'h00, rd_v);
		wr(`TOSP_OFS_CEP2, 8'hff);
		rd(`TOSP_OFS_CEP2, rd_v);
		chk_reg("cep2 reserved", 8'h3f, rd_v);
		wr(`TOSP_OFS_CEP2, 8'h00);
		rnd = $random(seed);
		d = rnd[15:0];
		wr(`TOSP_OFS_CNTH, d[15:8]);
		wr(`TOSP_OFS_CNTL, d[7:0]);
		rd(`TOSP_OFS_CNTH, rd_v);
		chk_reg("counter high", d[15:8], rd_v);
		rd(`TOSP_OFS_CNTL, rd_v);
		chk_reg("counter low", d[7:0], rd_v);
		chk("counter word", d, cnt_val);
		wr(`TOSP_OFS_CTRL, 8'h01);
		prev = 16'h0;
		for (i = 0; i < 3; i++) begin
			rnd = $random(seed);
			d = {13'h0, rnd[2:0]} + 16'h1;
			wr(`TOSP_OFS_DIVH, d[15:8]);
			wr(`TOSP_OFS_DIVL, d[7:0]);
			rd(`TOSP_OFS_DIVL, rd_v);
			chk_reg("divider low", d[7:0], rd_v);
			gap(n);
			chk("tick gap before update", prev + 16'h1, 16'(n));
			// each update source in turn, as software must after a divider change
			if (i == 0) fire(0);
			else if (i == 1) wr(`TOSP_OFS_CTRL, 8'h21);
			else fire(1);
			gap(n);
			chk("tick gap after update", d + 16'h1, 16'(n));
			prev = d;
		end
		wr(`TOSP_OFS_DEAD, 8'h03);
		// both enables cleared never happens while the channel is in use
		for (i = 1; i < 8; i++) if (i[1:0] != 2'h0) pins(i[0], i[1], i[2]);
		wr(`TOSP_OFS_CTRL, 8'h12);
		wr(`TOSP_OFS_CEP1, {4'h0, cp, 1'b0, mp, 1'b1});
		cyc(6);
		chk("compl oe before commutation", 16'h1, {15'h0, compl_oe[0]});
		fire(2);
		cyc(6);
		chk("compl oe after commutation", 16'h0, {15'h0, compl_oe[0]});
		wr(`TOSP_OFS_CTRL, 8'h00);
		wr(`TOSP_OFS_CEP1, 8'h00);
		@(posedge clk_sys);
		in_mode <= 4'h2;
		c0 = stb_n;
		fire(4);
		cyc(4);
		chk("capture gated", 16'(c0), 16'(stb_n));
		wr(`TOSP_OFS_CEP1, 8'h10);
		cyc(3);
		fire(4);
		cyc(4);
		chk("capture allowed", 16'(c0 + 1), 16'(stb_n));
		// main idle active, compl idle inactive, so the pair is never both on
		wr(`TOSP_OFS_IDLE, 8'h01);
		wr(`TOSP_OFS_CTRL, 8'h18);
		{mp, cp} = 2'h0;
		wr(`TOSP_OFS_CEP1, 8'h05);
		@(posedge clk_sys);
		ref_w <= 4'h0;
		cyc(8);
		@(posedge clk_sys);
		brk <= 1'b1;
		#1;
		chk("enable on break", 16'h0, {15'h0, out_en});
		cyc(12);
		chk("idle pins", 16'h000e, {12'h0, main_oe[0], main_pin, compl_oe[0], compl_pin});
		@(posedge clk_sys);
		brk <= 1'b0;
		wr(`TOSP_OFS_CTRL, 8'h00);
		cyc(8);
		chk("released pins", 16'h0, {12'h0, main_oe[0], main_pin, compl_oe[0], compl_pin});
		fire(3);
		cyc(2);
		chk("enable auto set", 16'h1, {15'h0, out_en});
		give_verdict();
	end
	// watchdog at 30000 cycles, well beyond the several hundred cycles the sequence needs
	initial begin
		#(20 * 30000);
		error_cnt++;
		give_verdict();
	end
endmodule
`default_nettype wire
